// ### core/hp_device.sv
// device end of the host memory port: on-chip program and data memory behind a strobed bus
// assumes host pins are asynchronous to mclk; processor side is a simple write and read port
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module hp_device (
    input wire logic mclk,
    input wire logic rst_n,
    hp_if.device hp,
    input wire logic mode_a,
    input wire logic mode_b,
    input wire logic mode_c,
    input wire logic proc_wr_en,
    input wire logic [hp_pkg::ADDR_W-1:0] proc_wr_addr,
    input wire logic [hp_pkg::DATA_W-1:0] proc_wr_data,
    input wire logic proc_rd_pm,
    input wire logic [hp_pkg::ADDR_W-1:0] proc_rd_addr,
    output logic [hp_pkg::PM_W-1:0] proc_rd_data,
    output logic [7:0] overlay_register,
    output logic processor_run
);
    import hp_pkg::*;

    logic [PM_W-1:0] program_memory [MEM_DEPTH];
    logic [DATA_W-1:0] data_memory [MEM_DEPTH];

    logic [22:0] pin_raw;
    logic [22:0] pin_s1;
    logic [22:0] pin_s2;
    logic sel;
    logic ale_s;
    logic rd;
    logic wr;
    logic [2:0] mode_s;
    logic [15:0] ad_s;
    logic sel_q;
    logic ale_q;
    logic latch_ev;
    logic proc_ctl_ev;
    logic ctl_ev;
    logic [15:0] ctl_word;
    hp_dev_state_t state;
    logic is_rd;
    logic [ADDR_W-1:0] latched_start_address;
    logic space_pm;
    logic half;
    logic [15:0] hi_hold;
    logic [7:0] low_byte;
    logic [15:0] rdata;
    logic drive;
    logic drive_ext;
    logic short_read_fast;
    logic [1:0] strap_cnt;
    logic boot_host;
    logic pm0_written;

    // every host pin, straps included, passes two flops before use
    assign pin_raw = {hp.host_addr_data_bus, mode_c, mode_b, mode_a, hp.host_write_strobe_n,
                      hp.host_read_strobe_n, hp.host_address_latch_strobe, hp.host_port_select_n};
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_s1 <= PIN_SYNC_RST;
            pin_s2 <= PIN_SYNC_RST;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end
    assign sel = ~pin_s2[0];
    assign ale_s = pin_s2[1];
    assign rd = ~pin_s2[2];
    assign wr = ~pin_s2[3];
    assign mode_s = pin_s2[6:4];
    assign ad_s = pin_s2[22:7];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sel_q <= 1'b0;
            ale_q <= 1'b0;
        end else begin
            sel_q <= sel;
            ale_q <= ale_s;
        end
    end

    // latch on the falling latch strobe, or on select going away while it is high
    assign latch_ev = ale_q & sel_q & (~ale_s | ~sel);
    assign proc_ctl_ev = proc_wr_en & (proc_wr_addr == CTRL_ADDR);
    // host latch wins if both land in one cycle
    assign ctl_ev = latch_ev | proc_ctl_ev;
    assign ctl_word = latch_ev ? ad_s : proc_wr_data;

    // data transaction: one cycle to synchronise, one to access memory
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            is_rd <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (sel & (rd | wr) & ~ale_s) begin
                        state <= ST_SYNC;
                        is_rd <= rd;
                    end
                end
                ST_SYNC: begin
                    state <= ST_ACCESS;
                end
                ST_ACCESS: begin
                    state <= ST_DONE;
                end
                default: begin
                    if (!(sel & (rd | wr))) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ack drops for the sync and access cycles only
    assign hp.host_port_ack = (state == ST_IDLE) | (state == ST_DONE);

    // address, space and half-word tracking
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            latched_start_address <= '0;
            space_pm <= 1'b0;
            half <= 1'b0;
            overlay_register <= 8'h00;
        end else if (ctl_ev) begin
            if (ctl_word[CW_OVL_BIT]) begin
                // bits 14:8 are ignored; host keeps them zero
                overlay_register <= ctl_word[CW_OVL_MSB:0];
            end else begin
                latched_start_address <= ctl_word[ADDR_W-1:0];
                space_pm <= ctl_word[CW_SPACE_BIT];
                half <= 1'b0;
            end
        end else if (state == ST_ACCESS) begin
            // a program word advances only after its second half
            if (!space_pm || half) begin
                latched_start_address <= latched_start_address + 14'h0001;
            end
            half <= space_pm & ~half;
        end
    end

    // memory side of the access cycle; a single cycle stolen per data-memory transfer, one per program word on its second half
    always_ff @(posedge mclk) begin
        if (state == ST_ACCESS && !is_rd) begin
            if (space_pm) begin
                if (half) begin
                    program_memory[latched_start_address] <= {hi_hold, ad_s[7:0]};
                end
            end else if (latched_start_address < MMR_BASE) begin
                data_memory[latched_start_address] <= ad_s;
            end
        end
    end

    // read data and write high-half holding
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hi_hold <= 16'h0000;
            low_byte <= 8'h00;
            rdata <= 16'h0000;
        end else if (state == ST_ACCESS) begin
            if (!is_rd) begin
                if (space_pm && !half) begin
                    hi_hold <= ad_s;
                end
            end else if (space_pm) begin
                if (!half) begin
                    rdata <= program_memory[latched_start_address][23:8];
                    low_byte <= program_memory[latched_start_address][7:0];
                end else begin
                    rdata <= {8'h00, low_byte};
                end
            end else begin
                // only memory contents reach the bus, never the latched address
                rdata <= data_memory[latched_start_address];
            end
        end
    end
    assign hp.ad_dev_o = rdata;
    assign hp.ad_dev_oe = drive;

    // short reads: fast mode releases the bus once the synchronised strobe release is seen, slow mode one cycle later
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            drive <= 1'b0;
            drive_ext <= 1'b0;
        end else begin
            drive_ext <= 1'b0;
            if (state == ST_ACCESS && is_rd) begin
                drive <= 1'b1;
            end else if (state == ST_DONE && !(sel & (rd | wr)) && drive) begin
                drive <= ~short_read_fast;
                drive_ext <= ~short_read_fast;
            end else if (drive_ext) begin
                drive <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            short_read_fast <= 1'b0;
        end else if (proc_wr_en && proc_wr_addr == SYSCTL_ADDR) begin
            short_read_fast <= proc_wr_data[SYSCTL_SHORT_RD_BIT];
        end
    end

    // straps are sampled once the synchroniser has filled after reset
    assign pm0_written = (state == ST_ACCESS) & ~is_rd & space_pm & half & (latched_start_address == 14'h0000);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strap_cnt <= 2'h0;
            boot_host <= 1'b0;
            processor_run <= 1'b0;
        end else if (strap_cnt != 2'h3) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == 2'h2) begin
                boot_host <= (mode_s == BOOT_HOST_PORT);
                processor_run <= (mode_s != BOOT_HOST_PORT);
            end
        end else if (boot_host && pm0_written) begin
            processor_run <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            proc_rd_data <= '0;
        end else if (proc_rd_pm) begin
            proc_rd_data <= program_memory[proc_rd_addr];
        end else begin
            proc_rd_data <= {8'h00, data_memory[proc_rd_addr]};
        end
    end
endmodule

// ### core/hp_pkg.sv
// constants and types shared by both ends of the host memory port
// assumes one system clock on both ends; host strobes are treated as asynchronous by the device
package hp_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    localparam int PM_W = 24;
    localparam int MEM_DEPTH = 16384;
    // control word layout
    localparam int CW_OVL_BIT = 15;
    localparam int CW_SPACE_BIT = 14;
    localparam int CW_OVL_MSB = 7;
    // processor-side memory-mapped locations
    localparam logic [13:0] CTRL_ADDR = 14'h3fe0;
    localparam logic [13:0] SYSCTL_ADDR = 14'h3fe7;
    localparam logic [13:0] MMR_BASE = 14'h3fe0;
    localparam int SYSCTL_SHORT_RD_BIT = 14;
    // boot straps {c,b,a} selecting boot through this port
    localparam logic [2:0] BOOT_HOST_PORT = 3'h5;
    // device pin synchroniser reset value: select, read, write idle high
    localparam logic [22:0] PIN_SYNC_RST = 23'h00000d;
    // host apb map
    localparam logic [7:0] APB_ADDR_CMD = 8'h00;
    localparam logic [7:0] APB_WDATA = 8'h04;
    localparam logic [7:0] APB_RDCMD = 8'h08;
    localparam logic [7:0] APB_STATUS = 8'h0c;
    localparam logic [7:0] APB_RDATA = 8'h10;
    // host engine timing in mclk cycles
    localparam logic [2:0] HOST_STROBE_CYC = 3'h3;
    localparam logic [2:0] HOST_GAP_CYC = 3'h4;
    localparam int FIFO_DEPTH = 16;
    localparam int CMD_W = 18;
    localparam logic [1:0] CMD_LATCH = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SYNC = 2'b01,
        ST_ACCESS = 2'b11,
        ST_DONE = 2'b10
    } hp_dev_state_t;
    typedef enum logic [2:0] {
        E_IDLE = 3'b000,
        E_LATCH = 3'b001,
        E_LHOLD = 3'b011,
        E_STRB = 3'b010,
        E_BUSY = 3'b110,
        E_GAP = 3'b100
    } hp_host_state_t;
endpackage

// ### core/hp_if.sv
// host port pins between the external host and the device
// assumes the bench instantiates it; the shared bus level is resolved here from the enables
`timescale 1ns/1ps
interface hp_if;
    logic host_port_select_n;
    logic host_address_latch_strobe;
    logic host_read_strobe_n;
    logic host_write_strobe_n;
    logic host_port_ack;
    logic [15:0] ad_host_o;
    logic ad_host_oe;
    logic [15:0] ad_dev_o;
    logic ad_dev_oe;
    logic [15:0] host_addr_data_bus;
    assign host_addr_data_bus = ad_dev_oe ? ad_dev_o : (ad_host_oe ? ad_host_o : 16'h0000);
    modport device (
        input host_port_select_n, host_address_latch_strobe, host_read_strobe_n, host_write_strobe_n,
        input host_addr_data_bus,
        output host_port_ack, ad_dev_o, ad_dev_oe
    );
    modport host (
        output host_port_select_n, host_address_latch_strobe, host_read_strobe_n, host_write_strobe_n,
        output ad_host_o, ad_host_oe,
        input host_port_ack, host_addr_data_bus
    );
endinterface

// ### core/hp_host.sv
// host end of the memory port: apb registers, a command fifo, and a strobe engine
// assumes ack and bus come from another device and are synchronised here
`timescale 1ns/1ps
module hp_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wp;
    logic [PW:0] rp;
    assign out_valid = wp != rp;
    assign in_ready = (wp[PW-1:0] != rp[PW-1:0]) | (wp[PW] == rp[PW]);
    assign out_data = mem[rp[PW-1:0]];
    always_ff @(posedge mclk) begin
        if (in_valid && in_ready) begin
            mem[wp[PW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp <= wp + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp <= rp + 1'b1;
            end
        end
    end
endmodule

module hp_host (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    hp_if.host hp
);
    import hp_pkg::*;

    logic [16:0] pin_s1;
    logic [16:0] pin_s2;
    logic ack_s;
    logic [15:0] ad_s;
    logic is_push;
    logic [1:0] push_kind;
    logic mapped;
    logic f_in_valid;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [CMD_W-1:0] f_out;
    hp_host_state_t state;
    logic [2:0] cnt;
    logic cmd_rd;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_set;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_s1 <= 17'h00000;
            pin_s2 <= 17'h00000;
        end else begin
            pin_s1 <= {hp.host_addr_data_bus, hp.host_port_ack};
            pin_s2 <= pin_s1;
        end
    end
    assign ack_s = pin_s2[0];
    assign ad_s = pin_s2[16:1];

    assign is_push = (paddr == APB_ADDR_CMD) | (paddr == APB_WDATA) | (paddr == APB_RDCMD);
    assign push_kind = (paddr == APB_ADDR_CMD) ? CMD_LATCH : ((paddr == APB_WDATA) ? CMD_WRITE : CMD_READ);
    assign mapped = is_push | (paddr == APB_STATUS) | (paddr == APB_RDATA);
    // a full fifo stalls the apb write until the engine drains it
    assign f_in_valid = psel & penable & pwrite & is_push;
    assign pready = (pwrite & is_push) ? f_in_ready : 1'b1;
    assign pslverr = psel & penable & ~mapped;

    hp_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data({push_kind, pwdata[15:0]}),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out)
    );

    // prdata is captured in the setup cycle so it stands through the access phase
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == APB_STATUS) begin
                prdata <= {28'h0000000, f_out_valid | (state != E_IDLE), rd_valid, ~f_in_ready, ack_s};
            end else if (paddr == APB_RDATA) begin
                prdata <= {16'h0000, rd_data};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // a completing read sets the flag even if software clears it in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
        end else if (rd_set) begin
            rd_valid <= 1'b1;
        end else if (psel && penable && !pwrite && paddr == APB_RDATA) begin
            rd_valid <= 1'b0;
        end
    end

    // new commands only start while the device shows idle
    assign f_out_ready = (state == E_IDLE) & ack_s;
    assign rd_set = (state == E_BUSY) & ack_s & cmd_rd;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= E_IDLE;
            cnt <= 3'h0;
            cmd_rd <= 1'b0;
            rd_data <= 16'h0000;
            hp.host_port_select_n <= 1'b1;
            hp.host_address_latch_strobe <= 1'b0;
            hp.host_read_strobe_n <= 1'b1;
            hp.host_write_strobe_n <= 1'b1;
            hp.ad_host_o <= 16'h0000;
            hp.ad_host_oe <= 1'b0;
        end else begin
            case (state)
                E_IDLE: begin
                    if (f_out_valid && ack_s) begin
                        hp.host_port_select_n <= 1'b0;
                        hp.ad_host_o <= f_out[15:0];
                        cmd_rd <= f_out[17:16] == CMD_READ;
                        hp.ad_host_oe <= f_out[17:16] != CMD_READ;
                        cnt <= HOST_STROBE_CYC;
                        if (f_out[17:16] == CMD_LATCH) begin
                            // bit 15 set carries an overlay; the caller keeps 14:8 zero
                            hp.host_address_latch_strobe <= 1'b1;
                            state <= E_LATCH;
                        end else begin
                            hp.host_read_strobe_n <= f_out[17:16] != CMD_READ;
                            hp.host_write_strobe_n <= f_out[17:16] != CMD_WRITE;
                            state <= E_STRB;
                        end
                    end
                end
                E_LATCH: begin
                    cnt <= cnt - 3'h1;
                    if (cnt == 3'h1) begin
                        hp.host_address_latch_strobe <= 1'b0;
                        cnt <= HOST_STROBE_CYC;
                        state <= E_LHOLD;
                    end
                end
                E_LHOLD: begin
                    cnt <= cnt - 3'h1;
                    if (cnt == 3'h1) begin
                        hp.host_port_select_n <= 1'b1;
                        hp.ad_host_oe <= 1'b0;
                        cnt <= HOST_GAP_CYC;
                        state <= E_GAP;
                    end
                end
                E_STRB: begin
                    if (!ack_s) begin
                        state <= E_BUSY;
                    end
                end
                E_BUSY: begin
                    // ack back high marks the previous operation complete
                    if (ack_s) begin
                        if (cmd_rd) begin
                            rd_data <= ad_s;
                        end
                        hp.host_port_select_n <= 1'b1;
                        hp.host_read_strobe_n <= 1'b1;
                        hp.host_write_strobe_n <= 1'b1;
                        hp.ad_host_oe <= 1'b0;
                        cnt <= HOST_GAP_CYC;
                        state <= E_GAP;
                    end
                end
                default: begin
                    cnt <= cnt - 3'h1;
                    if (cnt == 3'h1) begin
                        state <= E_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ### tb/hp_properties.sv
// wire-level checks on the pins joining the host end to the device end
// assumes every input is a plain copy of the shared interface signal of the same name
`timescale 1ns/1ps
module hp_properties (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic host_port_select_n,
    input wire logic host_address_latch_strobe,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic host_port_ack,
    input wire logic ad_host_oe,
    input wire logic ad_dev_oe,
    input wire logic [15:0] host_addr_data_bus
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence strobe_fall;
        ($fell(host_read_strobe_n) || $fell(host_write_strobe_n)) && !host_port_select_n;
    endsequence
    sequence busy_pulse;
        !host_port_ack [*2] ##1 host_port_ack;
    endsequence
    chk_ack_two_low: assert property ($fell(host_port_ack) |-> busy_pulse)
        else $error("ack low for other than two cycles");
    chk_ack_after_req: assert property (strobe_fall |-> ##[1:5] !host_port_ack)
        else $error("ack did not drop after a transfer request");
    chk_strobes_excl: assert property (!(!host_read_strobe_n && !host_write_strobe_n))
        else $error("read and write strobes low together");
    chk_strobe_sel: assert property (!host_read_strobe_n || !host_write_strobe_n |-> !host_port_select_n)
        else $error("strobe without select");
    chk_release_ack: assert property ($rose(host_read_strobe_n) || $rose(host_write_strobe_n) |-> $past(host_port_ack))
        else $error("strobe released before completion");
    chk_latch_width: assert property ($rose(host_address_latch_strobe) |->
        host_address_latch_strobe [*3] ##1 !host_address_latch_strobe)
        else $error("latch strobe width wrong");
    chk_latch_idle: assert property ($rose(host_address_latch_strobe) |-> host_port_ack && ad_host_oe)
        else $error("latch started while busy or undriven");
    chk_latch_stable: assert property (host_address_latch_strobe && $past(host_address_latch_strobe) |->
        $stable(host_addr_data_bus))
        else $error("bus moved during address latch");
    chk_dev_release: assert property (host_read_strobe_n [*6] |-> !ad_dev_oe)
        else $error("device drives bus outside a read");
    chk_no_clash: assert property (!host_write_strobe_n |-> !ad_dev_oe)
        else $error("device drives bus during a write");
endmodule

// ### tb/host_internal_memory_dma_port_tb.sv
// bench: apb drives the host end, which talks to the device end across the pin interface
// assumes one shared mclk; the processor side of the device is driven here directly
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module host_internal_memory_dma_port_tb;
    import hp_pkg::*;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err_r, pr_go, pr_go_d, fast;
    logic mode_a, mode_b, mode_c, proc_wr_en, proc_rd_pm, processor_run;
    logic [7:0] paddr, overlay_register, ov;
    logic [31:0] pwdata, prdata, rd_r;
    logic [13:0] proc_wr_addr, proc_rd_addr, base;
    logic [15:0] proc_wr_data;
    logic [15:0] d [20];
    logic [23:0] proc_rd_data, pw, ev;
    logic [23:0] exp_q [$];
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int oe_cnt = 0;
    hp_if hp ();
    hp_host i_hp_host (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hp(hp.host));
    hp_device i_hp_device (.mclk(mclk), .rst_n(rst_n), .hp(hp.device), .mode_a(mode_a), .mode_b(mode_b),
        .mode_c(mode_c), .proc_wr_en(proc_wr_en), .proc_wr_addr(proc_wr_addr), .proc_wr_data(proc_wr_data),
        .proc_rd_pm(proc_rd_pm), .proc_rd_addr(proc_rd_addr), .proc_rd_data(proc_rd_data),
        .overlay_register(overlay_register), .processor_run(processor_run));
    hp_properties i_hp_properties (.mclk(mclk), .rst_n(rst_n), .host_port_select_n(hp.host_port_select_n),
        .host_address_latch_strobe(hp.host_address_latch_strobe), .host_read_strobe_n(hp.host_read_strobe_n),
        .host_write_strobe_n(hp.host_write_strobe_n), .host_port_ack(hp.host_port_ack),
        .ad_host_oe(hp.ad_host_oe), .ad_dev_oe(hp.ad_dev_oe), .host_addr_data_bus(hp.host_addr_data_bus));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one full apb transfer; waits on pready with no assumed latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk iff pready);
        rd_r = prdata;
        err_r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic poll(input int b, input logic v);
        do apb(1'b0, APB_STATUS, 32'h0); while (rd_r[b] !== v);
    endtask
    // busy stays high between fifo entries, yet idle is confirmed twice
    task automatic drain();
        repeat (2) poll(3, 1'b0);
    endtask
    task automatic hrd(input logic [23:0] e);
        apb(1'b1, APB_RDCMD, 32'h0);
        poll(2, 1'b1);
        exp_q.push_back(e);
        apb(1'b0, APB_RDATA, 32'h0);
    endtask
    task automatic pchk(input logic pm, input logic [13:0] a, input logic [23:0] e);
        proc_rd_pm <= pm;
        proc_rd_addr <= a;
        exp_q.push_back(e);
        pr_go <= 1'b1;
        @(posedge mclk);
        pr_go <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic pwr(input logic [13:0] a, input logic [15:0] v);
        proc_wr_en <= 1'b1;
        proc_wr_addr <= a;
        proc_wr_data <= v;
        @(posedge mclk);
        proc_wr_en <= 1'b0;
        @(posedge mclk);
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        pr_go_d <= pr_go;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
        if (pr_go_d) begin
            ev = exp_q.pop_front();
            `CHK(proc_rd_data, ev)
        end
        if (psel && penable && pready && !pwrite && paddr == APB_RDATA) begin
            ev = exp_q.pop_front();
            `CHK({8'h0, prdata[15:0]}, ev)
        end
        // cycles the device keeps the bus after the read strobe is released
        if (hp.ad_dev_oe === 1'b1 && hp.host_read_strobe_n === 1'b1) begin
            oe_cnt++;
        end else if (oe_cnt != 0) begin
            `CHK(oe_cnt, fast ? 3 : 4)
            oe_cnt = 0;
        end
    end
    initial begin
        void'($urandom(32'hab39));
        {rst_n, psel, penable, pwrite, paddr, pwdata, pr_go, fast} = '0;
        {mode_c, mode_b, mode_a} = BOOT_HOST_PORT;
        {proc_wr_en, proc_wr_addr, proc_wr_data, proc_rd_pm, proc_rd_addr} = '0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK(processor_run, 1'b0)
        base = 14'($urandom_range(16'h1000));
        foreach (d[i]) d[i] = 16'($urandom);
        apb(1'b1, APB_ADDR_CMD, {18'h0, base});
        // twenty pushes outrun the engine, so the fifo is full after the last one, though no apb write waits on pready
        foreach (d[i]) apb(1'b1, APB_WDATA, {16'h0, d[i]});
        drain();
        foreach (d[i]) pchk(1'b0, base + 14'(i), {8'h0, d[i]});
        for (int m = 0; m < 2; m++) begin
            fast = (m == 1);
            pwr(SYSCTL_ADDR, 16'(m) << SYSCTL_SHORT_RD_BIT);
            apb(1'b1, APB_ADDR_CMD, {18'h0, base});
            for (int i = 0; i < 4; i++) hrd({8'h0, d[i]});
        end
        pwr(CTRL_ADDR, {2'b00, base + 14'd7});
        hrd({8'h0, d[7]});
        pw = 24'($urandom);
        apb(1'b1, APB_ADDR_CMD, 32'h4000);
        apb(1'b1, APB_WDATA, {16'h0, pw[23:8]});
        drain();
        `CHK(processor_run, 1'b0)
        apb(1'b1, APB_WDATA, {24'h0, pw[7:0]});
        apb(1'b1, APB_WDATA, {16'h0, ~pw[23:8]});
        apb(1'b1, APB_WDATA, {24'h0, ~pw[7:0]});
        drain();
        `CHK(processor_run, 1'b1)
        pchk(1'b1, 14'h0, pw);
        pchk(1'b1, 14'h1, ~pw);
        // program words read back through the port, high half first
        apb(1'b1, APB_ADDR_CMD, 32'h4000);
        hrd({8'h0, pw[23:8]});
        hrd({16'h0, pw[7:0]});
        hrd({8'h0, ~pw[23:8]});
        ov = 8'($urandom);
        apb(1'b1, APB_ADDR_CMD, {16'h0, 8'h80, ov});
        drain();
        `CHK(overlay_register, ov)
        // overlay select fields go back to zero as software must leave them
        apb(1'b1, APB_ADDR_CMD, 32'h8000);
        drain();
        `CHK(overlay_register, 8'h00)
        apb(1'b0, 8'h14, 32'h0);
        `CHK(err_r, 1'b1) // unmapped offset refused
        give_verdict();
    end
endmodule
